// [rtl/msdr_bank.sv]
`timescale 1ns/1ps
module msdr_bank import msdr_pkg::*; #(
  parameter logic [BANK_W-1:0] IDX = 2'h0
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  msdr_cmd_if.sink              cmd,
  input  wire logic [COL_W-1:0] burst_last,
  input  wire logic             full_page,
  output msdr_bank_type         state,
  output logic                  ap_pend,
  output logic [ROW_W-1:0]      open_row
);

  logic [COL_W-1:0] left;

  wire logic hit       = cmd.bank == IDX;
  wire logic close_hit = cmd.pre & (hit | cmd.pre_all);
  wire logic col_hit   = (cmd.col_rd | cmd.col_wr) & hit;
  wire logic col_other = (cmd.col_rd | cmd.col_wr) & ~hit;
  wire logic in_burst  = (state == BK_READ) | (state == BK_WRITE);
  // A column access elsewhere takes the shared data bus from this burst
  wire logic burst_end = in_burst & (col_other | cmd.stop | ((left == '0) & ~full_page));

  // Frozen entirely while the clock is suspended
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state    <= BK_IDLE;                                  // [R26]
      ap_pend  <= 1'b0;
      open_row <= '0;
      left     <= '0;
    end else if (cmd.run) begin
      if (cmd.act & hit) begin
        state    <= BK_ACTIVE;                              // [R18]
        open_row <= cmd.row;
      end else if (close_hit) begin
        state   <= BK_IDLE;
        ap_pend <= 1'b0;
      end else if (col_hit) begin
        state   <= cmd.col_rd ? BK_READ : BK_WRITE;         // [R19] [R23]
        ap_pend <= cmd.ap;
        left    <= burst_last;
      end else if (burst_end) begin
        state   <= ap_pend ? BK_IDLE : BK_ACTIVE;           // [R19]
        ap_pend <= 1'b0;
      end else if (in_burst) begin
        left <= left - COL_W'(1);
      end
    end
  end

endmodule

// [rtl/msdr_cmd_if.sv]
`timescale 1ns/1ps
interface msdr_cmd_if;
  import msdr_pkg::*;

  logic              run;
  logic              act;
  logic              col_rd;
  logic              col_wr;
  logic              pre;
  logic              pre_all;
  logic              stop;
  logic              ap;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0]  row;
  logic [COL_W-1:0]  col;

  modport source (output run, act, col_rd, col_wr, pre, pre_all, stop, ap, bank, row, col);
  modport sink   (input  run, act, col_rd, col_wr, pre, pre_all, stop, ap, bank, row, col);
endinterface

// [rtl/msdr_pkg.sv]
package msdr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int BANKS  = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int ROW_W  = 13;
  localparam int COL_W  = 9;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Address and mode register fields
  localparam int AP_BIT      = 10;
  localparam int EXT_SEL_BIT = 1;
  localparam int CL_LSB      = 4;
  localparam int CL_W        = 3;
  localparam int BT_BIT      = 3;
  localparam int BL_LSB      = 0;
  localparam int BL_W        = 3;

  localparam logic [CL_W-1:0] CL_THREE = 3'h3;
  localparam logic [BL_W-1:0] BL_TWO   = 3'h1;
  localparam logic [BL_W-1:0] BL_FOUR  = 3'h2;
  localparam logic [BL_W-1:0] BL_EIGHT = 3'h3;
  localparam logic [BL_W-1:0] BL_FULL  = 3'h7;

  localparam logic [COL_W-1:0] LAST_ONE   = 9'h000;
  localparam logic [COL_W-1:0] LAST_TWO   = 9'h001;
  localparam logic [COL_W-1:0] LAST_FOUR  = 9'h003;
  localparam logic [COL_W-1:0] LAST_EIGHT = 9'h007;

  // Latency three, sequential, single word
  localparam logic [ADDR_W-1:0] MODE_RESET     = 13'h0030;
  localparam logic [ADDR_W-1:0] EXT_MODE_RESET = 13'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS                    = 8000;
  localparam int ROW_CYCLE_TIME_NS                = 60;
  localparam int ACTIVATE_TO_COLUMN_DELAY_NS      = 18;
  localparam int MIN_ROW_ACTIVE_TIME_NS           = 42;
  localparam int BANK_TO_BANK_ACTIVATE_SPACING_NS = 12;
  localparam int MODE_WRITE_CYC                   = 2;

  localparam int CNT_W = 4;
  localparam int RC_CYC  = (ROW_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RCD_CYC = (ACTIVATE_TO_COLUMN_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;
  localparam int RAS_CYC = (MIN_ROW_ACTIVE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RRD_CYC = (BANK_TO_BANK_ACTIVATE_SPACING_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;

  localparam logic [CNT_W-1:0] RC_LIMIT   = CNT_W'(RC_CYC);
  localparam logic [CNT_W-1:0] RCD_LIMIT  = CNT_W'(RCD_CYC);
  localparam logic [CNT_W-1:0] RAS_LIMIT  = CNT_W'(RAS_CYC);
  localparam logic [CNT_W-1:0] RRD_LIMIT  = CNT_W'(RRD_CYC);
  localparam logic [CNT_W-1:0] RC_WAIT    = CNT_W'(RC_CYC - 1);
  localparam logic [CNT_W-1:0] MODE_WAIT  = CNT_W'(MODE_WRITE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  typedef enum logic [2:0] {
    CMD_MODE_WRITE = 3'h0,
    CMD_REFRESH    = 3'h1,
    CMD_PRECHARGE  = 3'h2,
    CMD_ACTIVATE   = 3'h3,
    CMD_WRITE      = 3'h4,
    CMD_READ       = 3'h5,
    CMD_BURST_STOP = 3'h6,
    CMD_NOP        = 3'h7
  } msdr_cmd_type;

  typedef enum logic [2:0] {
    DEV_NORMAL       = 3'h0,
    DEV_REFRESH      = 3'h1,
    DEV_MODE_ACCESS  = 3'h2,
    DEV_POWER_DOWN   = 3'h3,
    DEV_SELF_REFRESH = 3'h4
  } msdr_dev_type;

  typedef enum logic [1:0] {
    BK_IDLE   = 2'h0,
    BK_ACTIVE = 2'h1,
    BK_READ   = 2'h2,
    BK_WRITE  = 2'h3
  } msdr_bank_type;

  typedef enum logic [2:0] {
    FAULT_NONE        = 3'h0,
    FAULT_BANK_OPEN   = 3'h1,
    FAULT_BANK_CLOSED = 3'h2,
    FAULT_AUTO_CLOSE  = 3'h3,
    FAULT_NOT_IDLE    = 3'h4,
    FAULT_DEVICE_BUSY = 3'h5,
    FAULT_WAKE_CMD    = 3'h6
  } msdr_fault_type;

endpackage

// [rtl/msdr_rdpipe.sv]
`timescale 1ns/1ps
module msdr_rdpipe import msdr_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  msdr_cmd_if.sink               cmd,
  input  wire logic              cas_three,
  input  wire logic [COL_W-1:0]  burst_last,
  input  wire logic              full_page,
  input  wire logic              interleave,
  input  wire logic [ROW_W-1:0]  start_row,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   rd_req,
  output logic [BANK_W-1:0]      rd_bank,
  output logic [ROW_W-1:0]       rd_row,
  output logic [COL_W-1:0]       rd_col,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe
);

  logic              pend;
  logic [BANK_W-1:0] pend_bank;
  logic [ROW_W-1:0]  pend_row;
  logic [COL_W-1:0]  pend_col;
  logic              busy;
  logic [COL_W-1:0]  base;
  logic [COL_W-1:0]  step;
  logic [COL_W-1:0]  left;

  // Latency three holds the read one cycle; the older burst keeps issuing meanwhile
  wire logic              rd_now    = cmd.col_rd;
  wire logic              hold_now  = rd_now & cas_three;
  wire logic              start_now = (rd_now & ~cas_three) | pend;      // [R20] [R22]
  wire logic              halt      = cmd.stop | cmd.col_wr;
  wire logic              more_now  = busy & ~halt;
  wire logic              issue_now = start_now | more_now;
  wire logic [BANK_W-1:0] s_bank    = pend ? pend_bank : cmd.bank;
  wire logic [ROW_W-1:0]  s_row     = pend ? pend_row : start_row;
  wire logic [COL_W-1:0]  s_col     = pend ? pend_col : cmd.col;
  wire logic [COL_W-1:0]  mask      = full_page ? '1 : burst_last;
  wire logic [COL_W-1:0]  wrap      = interleave ? (base ^ step) : (base + step);
  wire logic [COL_W-1:0]  next_col  = (base & ~mask) | (wrap & mask);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend      <= 1'b0;
      pend_bank <= '0;
      pend_row  <= '0;
      pend_col  <= '0;
    end else if (cmd.run) begin
      pend <= hold_now;
      if (hold_now) begin
        pend_bank <= cmd.bank;
        pend_row  <= start_row;
        pend_col  <= cmd.col;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      busy    <= 1'b0;
      base    <= '0;
      step    <= '0;
      left    <= '0;
      rd_req  <= 1'b0;
      rd_bank <= '0;
      rd_row  <= '0;
      rd_col  <= '0;
    end else if (cmd.run) begin
      rd_req <= issue_now;
      if (start_now) begin
        busy    <= (burst_last != '0) | full_page;
        base    <= s_col;
        step    <= COL_W'(1);
        left    <= burst_last;
        rd_bank <= s_bank;
        rd_row  <= s_row;
        rd_col  <= s_col;
      end else if (more_now) begin
        busy   <= full_page | (left != COL_W'(1));
        step   <= step + COL_W'(1);
        left   <= left - COL_W'(1);
        rd_col <= next_col;
      end else begin
        busy <= 1'b0;
      end
    end
  end

  // Driver opens with the first fetch, one cycle ahead of the first word
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (cmd.run) begin
      if (rd_req) begin
        dq_out <= rd_data;
      end
      dq_oe <= issue_now | rd_req;                          // [R20] [R21]
    end
  end

endmodule

// [rtl/msdr_sdram.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01 - Refresh ends only after row cycle time
// R02 - Mode write returns idle two clocks later
// R03 - No commands while refreshing or mode access
// R04 - Busy bank refusal leaves other banks usable
// R05 - Activate then wait before column commands
// R06 - Keep row open minimum active time
// R07 - Space activations across banks
// R08 - Self refresh exits on quiet clock-enable rise
// R09 - Power down exits on quiet clock-enable rise
// R10 - First edge after wake carries no-operation
// R11 - Power down, self refresh, mode: idle only
// R12 - Refresh with clock enable falling: self refresh
// R13 - Idle with clock enable low: power down
// R14 - Otherwise clock enable low suspends clock
// R15 - Clock enable rise re-enables inputs at once
// R16 - Deselect ignores inputs, keeps all state
// R17 - No-operation starts nothing, work continues
// R18 - Activate opens addressed row until precharge
// R19 - Column commands take bank, column, auto-close
// R20 - Driver opens a clock before read latency
// R21 - Driver closes after final burst word
// R22 - Read may follow read on any clock
// R23 - Second read to open row stays valid
// R24 - Upper bank bit picks extended mode register
// R25 - Controller sends bank bits 00 or 10
// R26 - Reset leaves all banks idle, no burst
module msdr_sdram import msdr_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BANK_W-1:0] ba,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] rd_data,
  output logic                   rd_req,
  output logic [BANK_W-1:0]      rd_bank,
  output logic [ROW_W-1:0]       rd_row,
  output logic [COL_W-1:0]       rd_col,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe,
  output msdr_dev_type           dev_state,
  output logic [BANKS-1:0]       bank_open,
  output logic                   clock_suspended,
  output logic                   illegal_cmd,
  output msdr_fault_type         illegal_cause,
  output logic                   viol_col_delay,
  output logic                   viol_row_active,
  output logic                   viol_act_spacing,
  output logic [ADDR_W-1:0]      mode_reg,
  output logic [ADDR_W-1:0]      ext_mode_reg
);

  msdr_cmd_if cmd ();

  logic              cke_q;
  msdr_dev_type      next_state;
  logic [CNT_W-1:0]  wait_cnt;
  logic [CNT_W-1:0]  next_wait;
  msdr_fault_type    next_cause;
  logic [CNT_W-1:0]  rrd_age;
  logic [COL_W-1:0]  burst_last;
  msdr_bank_type     bank_state [BANKS];
  logic [ROW_W-1:0]  bank_row   [BANKS];
  logic [CNT_W-1:0]  act_age    [BANKS];
  logic [BANKS-1:0]  bank_ap;
  logic [BANKS-1:0]  bank_idle;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode

  msdr_cmd_type code;
  assign code = msdr_cmd_type'({ras_n, cas_n, we_n});

  wire logic selected = ~cs_n;
  wire logic quiet    = cs_n | (code == CMD_NOP);                   // [R16] [R17]
  wire logic all_idle = &bank_idle;
  // Commands count only when clock enable was high the cycle before
  wire logic live     = cke_q & (dev_state == DEV_NORMAL);          // [R03] [R14]

  wire logic is_mode  = selected & (code == CMD_MODE_WRITE);
  wire logic is_ref   = selected & (code == CMD_REFRESH);
  wire logic is_pre   = selected & (code == CMD_PRECHARGE);
  wire logic is_act   = selected & (code == CMD_ACTIVATE);
  wire logic is_rd    = selected & (code == CMD_READ);
  wire logic is_wr    = selected & (code == CMD_WRITE);
  wire logic is_stop  = selected & (code == CMD_BURST_STOP);
  wire logic is_col   = is_rd | is_wr;

  wire logic             tgt_idle    = bank_idle[ba];
  wire logic             tgt_ap      = bank_ap[ba];
  wire logic [CNT_W-1:0] tgt_age     = act_age[ba];
  wire logic             pre_all_req = addr[AP_BIT];
  // Auto-close rows are owned by the device until the burst finishes
  wire logic             pre_blocked = pre_all_req ? (|bank_ap) : tgt_ap;

  // Activate, column and single-bank precharge judge the addressed bank's state only
  wire logic ok_act  = live & is_act & tgt_idle;                    // [R04] [R18]
  wire logic ok_col  = live & is_col & ~tgt_idle & ~tgt_ap;         // [R04] [R19]
  wire logic ok_pre  = live & is_pre & ~pre_blocked;
  wire logic ok_mode = live & is_mode & all_idle;                   // [R11]
  wire logic ok_ref  = live & is_ref & all_idle;                    // [R11]

  assign cmd.run     = live;
  assign cmd.act     = ok_act;
  assign cmd.col_rd  = ok_col & is_rd;
  assign cmd.col_wr  = ok_col & is_wr;
  assign cmd.pre     = ok_pre;
  assign cmd.pre_all = pre_all_req;
  assign cmd.stop    = live & is_stop;
  assign cmd.ap      = addr[AP_BIT];                                // [R19]
  assign cmd.bank    = ba;
  assign cmd.row     = addr[ROW_W-1:0];
  assign cmd.col     = addr[COL_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Mode register fields

  wire logic            cas_three  = mode_reg[CL_LSB +: CL_W] == CL_THREE;
  wire logic [BL_W-1:0] bl_code    = mode_reg[BL_LSB +: BL_W];
  wire logic            interleave = mode_reg[BT_BIT];
  wire logic            full_page  = (bl_code == BL_FULL) & ~interleave;

  // Reserved burst codes fall back to a single word
  assign burst_last = (bl_code == BL_TWO)   ? LAST_TWO   :
                      (bl_code == BL_FOUR)  ? LAST_FOUR  :
                      (bl_code == BL_EIGHT) ? LAST_EIGHT : LAST_ONE;  // [R21]

  //////////////////////////////////////////////////////////////////////////////
  // Banks

  for (genvar i = 0; i < BANKS; i++) begin : g_bank
    msdr_bank #(
      .IDX (BANK_W'(i))
    ) u_bank (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .cmd        (cmd),
      .burst_last (burst_last),
      .full_page  (full_page),
      .state      (bank_state[i]),
      .ap_pend    (bank_ap[i]),
      .open_row   (bank_row[i])
    );

    assign bank_idle[i] = bank_state[i] == BK_IDLE;

    // Cycles since this bank was last activated, saturating
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        act_age[i] <= '1;
      end else if (ok_act & (ba == BANK_W'(i))) begin
        act_age[i] <= CNT_W'(1);
      end else if (act_age[i] != '1) begin
        act_age[i] <= act_age[i] + CNT_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data path

  msdr_rdpipe u_rdpipe (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .cmd        (cmd),
    .cas_three  (cas_three),
    .burst_last (burst_last),
    .full_page  (full_page),
    .interleave (interleave),
    .start_row  (bank_row[ba]),
    .rd_data    (rd_data),
    .rd_req     (rd_req),
    .rd_bank    (rd_bank),
    .rd_row     (rd_row),
    .rd_col     (rd_col),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Device state

  always_comb begin
    next_state = dev_state;
    next_wait  = wait_cnt;
    next_cause = FAULT_NONE;
    case (dev_state)
      DEV_NORMAL: begin
        if (live & is_act & ~tgt_idle) begin
          next_cause = FAULT_BANK_OPEN;
        end else if (live & is_col & tgt_idle) begin
          next_cause = FAULT_BANK_CLOSED;
        end else if (live & ((is_col & tgt_ap) | (is_pre & pre_blocked))) begin
          next_cause = FAULT_AUTO_CLOSE;
        end else if (live & (is_mode | is_ref) & ~all_idle) begin
          next_cause = FAULT_NOT_IDLE;                               // [R11]
        end
        if (ok_mode) begin
          next_state = DEV_MODE_ACCESS;                              // [R02]
          next_wait  = MODE_WAIT;
        end else if (ok_ref & cke) begin
          next_state = DEV_REFRESH;                                  // [R01]
          next_wait  = RC_WAIT;
        end else if (ok_ref) begin
          next_state = DEV_SELF_REFRESH;                             // [R12]
        end else if (~cke & all_idle & quiet) begin
          next_state = DEV_POWER_DOWN;                               // [R13]
        end
      end
      DEV_REFRESH, DEV_MODE_ACCESS: begin
        // Quiet cycles only wait; anything else is refused
        if (cke_q & ~quiet) begin
          next_cause = FAULT_DEVICE_BUSY;                            // [R03]
        end
        if (wait_cnt == '0) begin
          next_state = DEV_NORMAL;                                   // [R01] [R02]
        end else begin
          next_wait = wait_cnt - CNT_W'(1);
        end
      end
      DEV_POWER_DOWN, DEV_SELF_REFRESH: begin
        // Rise is seen at this very edge; a command with it is dropped
        if (~cke_q & cke) begin
          next_state = DEV_NORMAL;                                   // [R08] [R09] [R15]
          if (~quiet) begin
            next_cause = FAULT_WAKE_CMD;                             // [R10]
          end
        end
      end
      default: begin
        next_state = DEV_NORMAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cke_q     <= 1'b0;
      dev_state <= DEV_NORMAL;                                       // [R26]
      wait_cnt  <= '0;
    end else begin
      cke_q     <= cke;                                              // [R14]
      dev_state <= next_state;
      wait_cnt  <= next_wait;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode registers

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_reg     <= MODE_RESET;
      ext_mode_reg <= EXT_MODE_RESET;
    end else if (ok_mode & ba[EXT_SEL_BIT]) begin
      ext_mode_reg <= addr;                                          // [R24] [R25]
    end else if (ok_mode) begin
      mode_reg <= addr;                                              // [R24]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Controller timing watch; commands still execute, only flagged

  wire logic late_rcd = ok_col & (tgt_age < RCD_LIMIT);                   // [R05]
  wire logic late_ras = ok_pre & ~pre_all_req & ~tgt_idle & (tgt_age < RAS_LIMIT); // [R06]
  wire logic late_rrd = ok_act & ((rrd_age < RRD_LIMIT) | (tgt_age < RC_LIMIT)); // [R07]

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rrd_age <= '1;
    end else if (ok_act) begin
      rrd_age <= CNT_W'(1);
    end else if (rrd_age != '1) begin
      rrd_age <= rrd_age + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      viol_col_delay   <= 1'b0;
      viol_row_active  <= 1'b0;
      viol_act_spacing <= 1'b0;
    end else begin
      viol_col_delay   <= late_rcd;
      viol_row_active  <= late_ras;
      viol_act_spacing <= late_rrd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      illegal_cmd     <= 1'b0;
      illegal_cause   <= FAULT_NONE;
      clock_suspended <= 1'b0;
      bank_open       <= '0;
    end else begin
      illegal_cmd     <= next_cause != FAULT_NONE;
      illegal_cause   <= next_cause;
      clock_suspended <= ~cke & (next_state == DEV_NORMAL);          // [R14]
      bank_open       <= ~bank_idle;
    end
  end

endmodule

// [verif/msdr_ctrl_model.sv]
`timescale 1ns/1ps
module msdr_ctrl_model import msdr_pkg::*; (
  input  wire logic         ref_clk,
  output logic              cke,
  output logic              cs_n,
  output logic [2:0]        rcw,
  output logic [BANK_W-1:0] ba,
  output logic [ADDR_W-1:0] addr
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    rcw = 3'h7;
    ba = 2'h0;
    addr = 13'h0000;
  end
  // One command per cycle; callers keep idle-only, wake and spacing limits
  task automatic cyc(input msdr_cmd_type c, input logic [1:0] b, input logic [12:0] a,
                     input logic k);
    @(posedge ref_clk);
    cke <= k;
    cs_n <= 1'b0;
    rcw <= c;
    ba <= b;
    // Address is don't-care on a no-operation, so it toggles
    addr <= (c == CMD_NOP) ? ~addr : a;
  endtask
endmodule

// [verif/msdr_sdram_properties.sv]
`timescale 1ns/1ps
module msdr_sdram_properties import msdr_pkg::*; (
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic              cke,
  input wire logic              rd_req,
  input wire logic              dq_oe,
  input msdr_dev_type           dev_state,
  input wire logic [BANKS-1:0]  bank_open,
  input wire logic [ADDR_W-1:0] mode_reg,
  input wire logic [ADDR_W-1:0] ext_mode_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_RESET: assert property ($rose(nrst) |-> dev_state == DEV_NORMAL && !dq_oe)
    else $error("state not clear after reset");
  AST_REF_HOLD: assert property ($rose(dev_state == DEV_REFRESH) |->
    (dev_state == DEV_REFRESH)[*8] ##1 dev_state == DEV_NORMAL)
    else $error("refresh length wrong");
  AST_MODE_WAIT: assert property ($rose(dev_state == DEV_MODE_ACCESS) |=>
    dev_state == DEV_MODE_ACCESS ##1 dev_state == DEV_NORMAL)
    else $error("mode access length wrong");
  AST_MODE_SEL: assert property ($rose(dev_state == DEV_MODE_ACCESS) |->
    $stable(mode_reg) || $stable(ext_mode_reg))
    else $error("both mode registers written");
  AST_IDLE_ONLY: assert property (dev_state != DEV_NORMAL |-> bank_open == 4'h0)
    else $error("bank open outside normal state");
  AST_OE_FETCH: assert property (rd_req |-> dq_oe)
    else $error("driver off during fetch");
  AST_OE_END: assert property ($fell(rd_req) ##1 !rd_req[*2] |-> !dq_oe)
    else $error("driver on after burst");
  AST_WAKE: assert property (dev_state == DEV_POWER_DOWN && cke |->
    ##[1:2] dev_state == DEV_NORMAL)
    else $error("no wake from power down");
  cover property (dev_state == DEV_REFRESH);
  cover property ($rose(dq_oe));
  cover property (dev_state == DEV_POWER_DOWN ##1 dev_state == DEV_NORMAL);
endmodule
bind msdr_sdram msdr_sdram_properties msdr_sdram_properties_inst (
  .ref_clk, .nrst, .cke, .rd_req, .dq_oe, .dev_state, .bank_open, .mode_reg, .ext_mode_reg);

// [verif/msdr_sdram_test.sv]
`timescale 1ns/1ps
module msdr_sdram_test import msdr_pkg::*;;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cke, cs_n, rd_req, dq_oe, illegal_cmd;
  logic [2:0] rcw;
  logic [1:0] ba, rd_bank;
  logic [12:0] addr, mode_reg, ext_mode_reg, rd_row;
  logic [31:0] rd_data, dq_out;
  logic [8:0] rd_col;
  logic [3:0] bank_open;
  msdr_dev_type dev_state;
  msdr_fault_type illegal_cause;
  int n_fail = 0;
  int checks = 0;
  always #4 ref_clk = ~ref_clk;
  // Array stand-in: word carries its own address
  assign rd_data = {rd_bank, rd_row, 8'hA5, rd_col};
  msdr_ctrl_model msdr_ctrl_model_inst (.ref_clk, .cke, .cs_n, .rcw, .ba, .addr);
  msdr_sdram msdr_sdram_inst (.ref_clk, .nrst, .cke, .cs_n, .ras_n(rcw[2]), .cas_n(rcw[1]),
    .we_n(rcw[0]), .ba, .addr, .rd_data, .rd_req, .rd_bank, .rd_row, .rd_col, .dq_out, .dq_oe,
    .dev_state, .bank_open, .clock_suspended(), .illegal_cmd, .illegal_cause,
    .viol_col_delay(), .viol_row_active(), .viol_act_spacing(), .mode_reg, .ext_mode_reg);
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmd(msdr_cmd_type c, logic [1:0] b = 2'h0, logic [12:0] a = 13'h0000,
                     logic k = 1'b1);
    msdr_ctrl_model_inst.cyc(c, b, a, k);
  endtask
  task automatic no_operation_command(int n);
    repeat (n) cmd(CMD_NOP);
    #1;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_mode();
    no_operation_command(1);
    chk("mode_reg", MODE_RESET, mode_reg);
    cmd(CMD_MODE_WRITE, 2'h0, 13'h0021);
    no_operation_command(2);
    chk("dev_state", DEV_MODE_ACCESS, dev_state);
    no_operation_command(1);
    chk("dev_state", DEV_NORMAL, dev_state);
    cmd(CMD_MODE_WRITE, 2'h2, 13'h0005);
    no_operation_command(4);
    chk("modes", {13'h0021, 13'h0005}, {mode_reg, ext_mode_reg});
  endtask
  task automatic t_refresh();
    cmd(CMD_REFRESH);
    no_operation_command(2);
    cmd(CMD_ACTIVATE, 2'h0, 13'h0001);
    no_operation_command(1);
    chk("illegal_cause", FAULT_DEVICE_BUSY, illegal_cause);
    chk("illegal_cmd", 1'b1, illegal_cmd);
    no_operation_command(4);
    chk("dev_state", DEV_REFRESH, dev_state);
    no_operation_command(1);
    chk("dev_state", DEV_NORMAL, dev_state);
  endtask
  task automatic t_read();
    cmd(CMD_ACTIVATE, 2'h1, 13'h0123);
    no_operation_command(3);
    chk("bank_open", 4'h2, bank_open);
    cmd(CMD_READ, 2'h1, 13'h0004);
    cmd(CMD_READ, 2'h1, 13'h0008);
    no_operation_command(1);
    chk("fetch", {1'b1, 2'h1, 13'h0123, 9'h008}, {rd_req, rd_bank, rd_row, rd_col});
    chk("dq_out", {2'h1, 13'h0123, 8'hA5, 9'h004}, dq_out);
    no_operation_command(1);
    chk("dq_out", {2'h1, 13'h0123, 8'hA5, 9'h008}, dq_out);
    no_operation_command(1);
    chk("dq_out", {2'h1, 13'h0123, 8'hA5, 9'h009}, dq_out);
    no_operation_command(1);
    chk("dq_oe", 1'b0, dq_oe);
  endtask
  task automatic t_banks();
    cmd(CMD_ACTIVATE, 2'h1, 13'h0055);
    no_operation_command(1);
    chk("illegal_cause", FAULT_BANK_OPEN, illegal_cause);
    cmd(CMD_ACTIVATE, 2'h2, 13'h0077);
    no_operation_command(7);
    chk("bank_open", 4'h6, bank_open);
    cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
    no_operation_command(3);
    chk("bank_open", 4'h0, bank_open);
  endtask
  task automatic t_sleep(msdr_cmd_type c, msdr_dev_type d, int n);
    cmd(c, 2'h0, 13'h0000, 1'b0);
    repeat (3) cmd(CMD_NOP, 2'h0, 13'h0000, 1'b0);
    #1;
    chk("dev_state", d, dev_state);
    no_operation_command(n);
    chk("dev_state", DEV_NORMAL, dev_state);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_mode();
    t_refresh();
    t_read();
    t_banks();
    t_sleep(CMD_NOP, DEV_POWER_DOWN, 3);
    t_sleep(CMD_REFRESH, DEV_SELF_REFRESH, 20);
    results();
  end
  initial begin
    repeat (1000) @(posedge ref_clk);
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    results();
  end
endmodule
